// file: codec_mixer_format_regs.sv
// indexed mixer attenuation and clock/data format register bank
`timescale 1ns/1ns
`default_nettype none
`include "codec_mixer_format_defs.svh"

module codec_mixer_format_regs
  import codec_mixer_format_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // host register port
  input  wire logic [1:0] host_addr_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic [7:0] host_wdata_in,
  output logic      [7:0] host_rdata_out,
  // qualifying state from the rest of the codec
  input  wire logic       mode_change_state_in,
  input  wire logic       playback_enable_in,
  input  wire logic       extended_register_mode_in,
  // auxiliary B mixer controls
  output logic            left_aux_b_mute_out,
  output logic      [4:0] left_aux_b_atten_out,
  output logic            right_aux_b_mute_out,
  output logic      [4:0] right_aux_b_atten_out,
  // DAC controls
  output logic            left_dac_mute_out,
  output logic      [5:0] left_dac_atten_out,
  output logic            right_dac_mute_out,
  output logic      [5:0] right_dac_atten_out,
  // clock and data format
  output logic            rate_source_sel_out,
  output logic      [2:0] rate_divide_sel_out,
  output logic            rate_reserved_out,
  output logic            rate_table_active_out,
  output logic            stereo_out,
  output logic            mono_duplicate_out,
  output logic            companded_out,
  output logic      [1:0] data_format_sel_out,
  output data_type_t      data_type_out,
  output logic            format_write_unsafe_out
);

  // host-side state
  logic [3:0] register_index_ff;
  logic [3:0] nxt_register_index;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       unsafe_ff;
  logic       nxt_unsafe;

  // decoded strobes
  logic       data_wr;
  logic       wr_left_aux;
  logic       wr_right_aux;
  logic       wr_left_dac;
  logic       wr_right_dac;
  logic       wr_format;

  // register contents
  logic [7:0] left_aux_q;
  logic [7:0] right_aux_q;
  logic [7:0] left_dac_q;
  logic [7:0] right_dac_q;
  logic [7:0] format_q;
  logic [7:0] indexed_rdata;
  logic [2:0] fmt_code;

  // an access to the data address lands on whatever index was last written
  assign data_wr      = host_wr_in && (host_addr_in == `CMF_ADR_DATA);
  assign wr_left_aux  = data_wr && (register_index_ff == `CMF_IDX_LEFT_AUX2);
  assign wr_right_aux = data_wr && (register_index_ff == `CMF_IDX_RIGHT_AUX2);
  assign wr_left_dac  = data_wr && (register_index_ff == `CMF_IDX_LEFT_DAC);
  assign wr_right_dac = data_wr && (register_index_ff == `CMF_IDX_RIGHT_DAC);
  assign wr_format    = data_wr && (register_index_ff == `CMF_IDX_FORMAT);

  // reserved bits are masked off on write rather than checked
  cfg_reg8 #(
    .RESET_VAL (`CMF_RST_AUX2),
    .WR_MASK   (`CMF_MASK_AUX2)
  ) u_left_aux (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_left_aux),
    .wdata_in (host_wdata_in),
    .q_out    (left_aux_q)
  );

  cfg_reg8 #(
    .RESET_VAL (`CMF_RST_AUX2),
    .WR_MASK   (`CMF_MASK_AUX2)
  ) u_right_aux (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_right_aux),
    .wdata_in (host_wdata_in),
    .q_out    (right_aux_q)
  );

  cfg_reg8 #(
    .RESET_VAL (`CMF_RST_DAC),
    .WR_MASK   (`CMF_MASK_DAC)
  ) u_left_dac (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_left_dac),
    .wdata_in (host_wdata_in),
    .q_out    (left_dac_q)
  );

  cfg_reg8 #(
    .RESET_VAL (`CMF_RST_DAC),
    .WR_MASK   (`CMF_MASK_DAC)
  ) u_right_dac (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_right_dac),
    .wdata_in (host_wdata_in),
    .q_out    (right_dac_q)
  );

  // rate bits are taken with no mode-change qualification
  cfg_reg8 #(
    .RESET_VAL (`CMF_RST_FORMAT),
    .WR_MASK   (`CMF_MASK_FORMAT)
  ) u_format (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_format),
    .wdata_in (host_wdata_in),
    .q_out    (format_q)
  );

  // field outputs straight from the stored registers
  assign left_aux_b_mute_out   = left_aux_q[`CMF_MUTE_BIT];
  assign left_aux_b_atten_out  = left_aux_q[`CMF_AUX_ATTEN_MSB:0];
  assign right_aux_b_mute_out  = right_aux_q[`CMF_MUTE_BIT];
  assign right_aux_b_atten_out = right_aux_q[`CMF_AUX_ATTEN_MSB:0];
  assign left_dac_mute_out     = left_dac_q[`CMF_MUTE_BIT];
  assign left_dac_atten_out    = left_dac_q[`CMF_DAC_ATTEN_MSB:0];
  assign right_dac_mute_out    = right_dac_q[`CMF_MUTE_BIT];
  assign right_dac_atten_out   = right_dac_q[`CMF_DAC_ATTEN_MSB:0];

  // sample rate selection
  assign rate_source_sel_out = format_q[`CMF_SRC_BIT];
  assign rate_divide_sel_out = format_q[`CMF_DIV_MSB:`CMF_DIV_LSB];
  // divide 100/101 have no rate on the first source
  assign rate_reserved_out   = !format_q[`CMF_SRC_BIT]
                               && (format_q[`CMF_DIV_MSB:`CMF_DIV_MSB-1]
                                   == 2'h2);
  // in extended mode the rate comes from the separate frequency registers
  assign rate_table_active_out = !extended_register_mode_in;

  // channel arrangement
  assign stereo_out         = format_q[`CMF_STEREO_BIT];
  assign mono_duplicate_out = !format_q[`CMF_STEREO_BIT];

  // data type
  assign companded_out       = format_q[`CMF_COMPAND_BIT];
  assign data_format_sel_out = format_q[`CMF_FMT_MSB:`CMF_FMT_LSB];
  assign fmt_code = {format_q[`CMF_FMT_MSB:`CMF_FMT_LSB],
                     format_q[`CMF_COMPAND_BIT]};

  always_comb begin
    case (fmt_code)
      3'h0:    data_type_out = DT_LIN8_U;
      3'h1:    data_type_out = DT_MULAW;
      3'h2:    data_type_out = DT_LIN16_LE;
      3'h3:    data_type_out = DT_ALAW;
      3'h6:    data_type_out = DT_LIN16_BE;
      default: data_type_out = DT_RESERVED;
    endcase
  end

  // read mux over the indexed registers
  always_comb begin
    if (register_index_ff == `CMF_IDX_LEFT_AUX2) begin
      indexed_rdata = left_aux_q;
    end else if (register_index_ff == `CMF_IDX_RIGHT_AUX2) begin
      indexed_rdata = right_aux_q;
    end else if (register_index_ff == `CMF_IDX_LEFT_DAC) begin
      indexed_rdata = left_dac_q;
    end else if (register_index_ff == `CMF_IDX_RIGHT_DAC) begin
      indexed_rdata = right_dac_q;
    end else if (register_index_ff == `CMF_IDX_FORMAT) begin
      indexed_rdata = format_q;
    end else begin
      indexed_rdata = 8'h00;
    end
  end

  // index, read data and unsafe-change flag
  always_comb begin
    nxt_register_index = register_index_ff;
    nxt_rdata          = rdata_ff;
    nxt_unsafe         = 1'b0;
    if (host_wr_in && (host_addr_in == `CMF_ADR_INDEX)) begin
      nxt_register_index = host_wdata_in[3:0];
    end
    if (host_rd_in) begin
      if (host_addr_in == `CMF_ADR_INDEX) begin
        nxt_rdata = {4'h0, register_index_ff};
      end else if (host_addr_in == `CMF_ADR_DATA) begin
        nxt_rdata = indexed_rdata;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
    // the write is still taken; this only tells the codec it was unsafe
    if (wr_format && !mode_change_state_in && playback_enable_in
        && (host_wdata_in[7:4] != format_q[7:4])) begin
      nxt_unsafe = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      register_index_ff <= 4'h0;
      rdata_ff          <= 8'h00;
      unsafe_ff         <= 1'b0;
    end else begin
      register_index_ff <= nxt_register_index;
      rdata_ff          <= nxt_rdata;
      unsafe_ff         <= nxt_unsafe;
    end
  end

  assign host_rdata_out          = rdata_ff;
  assign format_write_unsafe_out = unsafe_ff;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_data_wr(logic [3:0] idx);
    host_wr_in && (host_addr_in == `CMF_ADR_DATA)
      && (register_index_ff == idx);
  endsequence

  sequence seq_data_rd(logic [3:0] idx);
    host_rd_in && (host_addr_in == `CMF_ADR_DATA)
      && (register_index_ff == idx);
  endsequence

  AST_RESET_VALUES: assert property (
    $fell(rst_in) |-> left_aux_b_mute_out && right_aux_b_mute_out
      && left_dac_mute_out && right_dac_mute_out
      && (left_aux_b_atten_out == `CMF_AUX_UNITY) && (format_q == 8'h00))
    else $error("register values wrong after reset");

  AST_LEFT_AUX_WRITE: assert property (
    seq_data_wr(`CMF_IDX_LEFT_AUX2) |=>
      (left_aux_b_atten_out == $past(host_wdata_in[4:0]))
      && (left_aux_b_mute_out == $past(host_wdata_in[7])))
    else $error("left aux write not stored");

  AST_RIGHT_AUX_WRITE: assert property (
    seq_data_wr(`CMF_IDX_RIGHT_AUX2) |=>
      (right_aux_b_atten_out == $past(host_wdata_in[4:0]))
      && (right_aux_b_mute_out == $past(host_wdata_in[7])))
    else $error("right aux write not stored");

  AST_LEFT_DAC_WRITE: assert property (
    seq_data_wr(`CMF_IDX_LEFT_DAC) |=>
      (left_dac_atten_out == $past(host_wdata_in[5:0]))
      && (left_dac_mute_out == $past(host_wdata_in[7])))
    else $error("left dac write not stored");

  AST_RIGHT_DAC_WRITE: assert property (
    seq_data_wr(`CMF_IDX_RIGHT_DAC) |=>
      (right_dac_atten_out == $past(host_wdata_in[5:0]))
      && (right_dac_mute_out == $past(host_wdata_in[7])))
    else $error("right dac write not stored");

  AST_RATE_ANYTIME: assert property (
    (seq_data_wr(`CMF_IDX_FORMAT) ##0 !mode_change_state_in) |=>
      (rate_divide_sel_out == $past(host_wdata_in[3:1]))
      && (rate_source_sel_out == $past(host_wdata_in[0])))
    else $error("rate change refused outside mode change");

  AST_DAC_READBACK: assert property (
    seq_data_rd(`CMF_IDX_LEFT_DAC) |=>
      (host_rdata_out == {$past(left_dac_mute_out), 1'b0,
                          $past(left_dac_atten_out)}))
    else $error("dac readback wrong");

  // both directions: reserved codes flagged, every real rate left clear
  AST_RATE_RESERVED: assert property (
    rate_reserved_out == (!rate_source_sel_out
      && (rate_divide_sel_out inside {3'h4, 3'h5})))
    else $error("reserved rate not flagged");

  AST_DATA_TYPE: assert property (
    (data_format_sel_out == 2'h2) |-> (data_type_out == DT_RESERVED))
    else $error("reserved format not decoded");

endmodule

`default_nettype wire

// file: codec_mixer_format_defs.svh
// offsets, field positions, reset values and masks of the mixer/format bank
`ifndef CODEC_MIXER_FORMAT_DEFS_SVH
`define CODEC_MIXER_FORMAT_DEFS_SVH

// direct host addresses (two address pins)
`define CMF_ADR_INDEX        2'h0
`define CMF_ADR_DATA         2'h1

// indirect register indices
`define CMF_IDX_LEFT_AUX2    4'h4
`define CMF_IDX_RIGHT_AUX2   4'h5
`define CMF_IDX_LEFT_DAC     4'h6
`define CMF_IDX_RIGHT_DAC    4'h7
`define CMF_IDX_FORMAT       4'h8

// reset values, unknown bits taken as zero
`define CMF_RST_AUX2         8'h88
`define CMF_RST_DAC          8'h80
`define CMF_RST_FORMAT       8'h00

// writable bits; everything else is reserved and reads zero
`define CMF_MASK_AUX2        8'h9F
`define CMF_MASK_DAC         8'hBF
`define CMF_MASK_FORMAT      8'hFF

// field positions
`define CMF_MUTE_BIT         7
`define CMF_AUX_ATTEN_MSB    4
`define CMF_DAC_ATTEN_MSB    5
`define CMF_SRC_BIT          0
`define CMF_DIV_MSB          3
`define CMF_DIV_LSB          1
`define CMF_STEREO_BIT       4
`define CMF_COMPAND_BIT      5
`define CMF_FMT_MSB          7
`define CMF_FMT_LSB          6

// unity-gain code of the auxiliary attenuator
`define CMF_AUX_UNITY        5'h08

`endif

// file: codec_mixer_format_pkg.sv
// types shared by the mixer/format register bank
package codec_mixer_format_pkg;

  // encoded as {format select, companded bit}
  typedef enum logic [2:0] {
    DT_LIN8_U    = 3'h0,
    DT_MULAW     = 3'h1,
    DT_LIN16_LE  = 3'h2,
    DT_ALAW      = 3'h3,
    DT_LIN16_BE  = 3'h6,
    DT_RESERVED  = 3'h7
  } data_type_t;

endpackage

// file: cfg_reg8.sv
// one 8-bit control register with reset value and writable-bit mask
`timescale 1ns/1ns
`default_nettype none

module cfg_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // write port
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // stored value
  output logic      [7:0] q_out
);

  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  // reserved bits are never stored, so they always read back zero
  always_comb begin
    nxt_q = q_ff;
    if (wr_in) begin
      nxt_q = wdata_in & WR_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= RESET_VAL & WR_MASK;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;

endmodule

`default_nettype wire

// file: host_bus_model.sv
// host processor model driving the index/data register port
`timescale 1ns/1ns
`default_nettype none
`include "codec_mixer_format_defs.svh"

module host_bus_model (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic      [1:0] addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] wdata_out
);
  initial begin
    addr_out  = 2'h3;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // one strobe cycle; released lines show junk, not the last value
  task automatic cyc(input logic [1:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wr_out    <= w;
    rd_out    <= !w;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  // index first, then the data access
  task automatic wr_reg(input logic [3:0] i, input logic [7:0] d);
    cyc(`CMF_ADR_INDEX, 1'b1, {4'h0, i});
    cyc(`CMF_ADR_DATA, 1'b1, d);
  endtask

  task automatic rd_reg(input logic [3:0] i);
    cyc(`CMF_ADR_INDEX, 1'b1, {4'h0, i});
    cyc(`CMF_ADR_DATA, 1'b0, 8'h00);
  endtask
endmodule

`default_nettype wire

// file: testbench.sv
// self-checking bench for the mixer and format register bank
`timescale 1ns/1ns
`default_nettype none
`include "codec_mixer_format_defs.svh"

module testbench
  import codec_mixer_format_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       mode_change_state = 1'b0;
  logic       playback_enable = 1'b0;
  logic       extended_register_mode = 1'b0;
  logic [1:0] addr;
  logic       wr, rd, rd_seen = 1'b0;
  logic [7:0] wdata, rdata;
  logic       la_m, ra_m, ld_m, rdac_m, src, rsv, tbl, st, mono, cmp, unsafe;
  logic [4:0] la_att, ra_att;
  logic [5:0] ld_att, rdac_att;
  logic [2:0] div;
  logic [1:0] fmt;
  data_type_t dtype;
  logic [7:0] mdl [4:8];
  logic [7:0] expq [$];
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;

  always #10 clk_in = ~clk_in;

  host_bus_model hm (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));

  codec_mixer_format_regs dut (.clk_in(clk_in), .rst_in(rst_in),
    .host_addr_in(addr), .host_wr_in(wr), .host_rd_in(rd),
    .host_wdata_in(wdata), .host_rdata_out(rdata),
    .mode_change_state_in(mode_change_state),
    .playback_enable_in(playback_enable),
    .extended_register_mode_in(extended_register_mode),
    .left_aux_b_mute_out(la_m), .left_aux_b_atten_out(la_att),
    .right_aux_b_mute_out(ra_m), .right_aux_b_atten_out(ra_att),
    .left_dac_mute_out(ld_m), .left_dac_atten_out(ld_att),
    .right_dac_mute_out(rdac_m), .right_dac_atten_out(rdac_att),
    .rate_source_sel_out(src), .rate_divide_sel_out(div),
    .rate_reserved_out(rsv), .rate_table_active_out(tbl),
    .stereo_out(st), .mono_duplicate_out(mono), .companded_out(cmp),
    .data_format_sel_out(fmt), .data_type_out(dtype),
    .format_write_unsafe_out(unsafe));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read data is registered, so it is judged one edge after the strobe
  always @(posedge clk_in) begin
    if (rd_seen)
      check(rdata, expq.pop_front());
    rd_seen <= rd && !rst_in;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end

  function automatic logic [7:0] msk(input logic [3:0] i);
    return i < 4'h6 ? `CMF_MASK_AUX2 :
           i < 4'h8 ? `CMF_MASK_DAC : `CMF_MASK_FORMAT;
  endfunction

  task automatic rd_exp(input logic [3:0] i, input logic [7:0] e);
    expq.push_back(e);
    hm.rd_reg(i);
  endtask

  task automatic put(input logic [3:0] i, input logic [7:0] d);
    hm.wr_reg(i, d);
    mdl[i] = d & msk(i);
    #1;
  endtask

  task automatic check_all;
    check({la_m, 2'h0, la_att}, mdl[4]);
    check({ra_m, 2'h0, ra_att}, mdl[5]);
    check({ld_m, 1'b0, ld_att}, mdl[6]);
    check({rdac_m, 1'b0, rdac_att}, mdl[7]);
    check({fmt, cmp, st, div, src}, mdl[8]);
    for (int i = 4; i <= 8; i++)
      rd_exp(4'(i), mdl[i]);
  endtask

  task automatic fmt_checks(input logic u);
    logic [7:0] f;
    f = mdl[8];
    check(8'(unsafe), 8'(u));
    check(8'({div, src}), 8'(f[3:0]));
    check(8'(rsv), 8'(f[3:0] == 4'h8 || f[3:0] == 4'hA));
    check(8'(mono), 8'(!f[4]));
    check(8'(dtype), 8'(f[7:5] inside {3'h4, 3'h5} ? 3'h7 : f[7:5]));
  endtask

  initial begin
    void'($urandom(22));
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    mdl = '{8'h88, 8'h88, 8'h80, 8'h80, 8'h00};
    check_all;
    $display("reset values done");
    // all zeros, all ones into reserved bits, then masked random
    for (int n = 0; n < 6; n++) begin
      for (int i = 4; i < 8; i++)
        put(4'(i), n == 0 ? 8'h00 : n == 1 ? 8'hFF :
            8'($urandom) & msk(4'(i)));
      check_all;
    end
    $display("mixer registers done");
    @(posedge clk_in) mode_change_state <= 1'b1;
    @(posedge clk_in) playback_enable <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      put(4'h8, {3'(c), 5'($urandom)});
      fmt_checks(1'b0);
    end
    // rate bits may change while playing outside mode change
    @(posedge clk_in) mode_change_state <= 1'b0;
    for (int r = 0; r < 16; r++) begin
      put(4'h8, {mdl[8][7:4], 4'(r)});
      fmt_checks(1'b0);
    end
    put(4'h8, mdl[8] ^ 8'h10);
    fmt_checks(1'b1);
    @(posedge clk_in) playback_enable <= 1'b0;
    put(4'h8, mdl[8] ^ 8'h30);
    fmt_checks(1'b0);
    check_all;
    $display("format register done");
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_in) extended_register_mode <= 1'(e);
      @(posedge clk_in) #1;
      check(8'(tbl), 8'(e == 0));
    end
    $display("extended mode done");
    hm.wr_reg(4'h9, 8'h5A);
    rd_exp(4'h9, 8'h00);
    expq.push_back(8'h09);
    hm.cyc(`CMF_ADR_INDEX, 1'b0, 8'h00);
    expq.push_back(8'h00);
    hm.cyc(2'h2, 1'b0, 8'h00);
    check_all;
    $display("index and unmapped done");
    @(posedge clk_in) rst_in <= 1'b1;
    @(posedge clk_in) rst_in <= 1'b0;
    expq.push_back(8'h00);
    hm.cyc(`CMF_ADR_INDEX, 1'b0, 8'h00);
    mdl = '{8'h88, 8'h88, 8'h80, 8'h80, 8'h00};
    #1;
    check_all;
    repeat (3) @(posedge clk_in);
    check(8'(expq.size()), 8'h00);
    $display("second reset done");
    end_of_test;
  end
endmodule

`default_nettype wire
